// [rlc_pkg.sv]
package rlc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INIT = 8'h04;
  localparam logic [7:0] ADDR_ETH = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_CNT = 8'h10;

  // Field positions
  localparam int INIT_HFN_LSB = 0;
  localparam int INIT_BFN_LSB = 16;
  localparam int CNT_HFN_LSB = 0;
  localparam int CNT_BFN_LSB = 16;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] INIT_RST = 32'h0000_0000;
  localparam logic [5:0] ETH_RST = 6'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int DWELL_NS = 10000;
  localparam int DWELL_CYC = (DWELL_NS * 1000 + CLK_PERIOD_PS - 1) /
                             CLK_PERIOD_PS;
  localparam int FAST_CYC = 4;
  localparam int LOF_NS = 1000;
  localparam int LOF_CYC = (LOF_NS * 1000 + CLK_PERIOD_PS - 1) /
                           CLK_PERIOD_PS;

  // Frame counting
  localparam logic [7:0] HFN_LAST = 8'h95;
  localparam logic [5:0] ETH_PTR_MIN = 6'h14;

  // Start-up status codes
  localparam logic [2:0] STUP_STANDBY = 3'h0;
  localparam logic [2:0] STUP_SYNC = 3'h1;
  localparam logic [2:0] STUP_PROTO = 3'h2;
  localparam logic [2:0] STUP_CM = 3'h3;
  localparam logic [2:0] STUP_VENDOR = 3'h4;
  localparam logic [2:0] STUP_OPER = 3'h5;

  // Slow control rate codes
  localparam logic [2:0] HDLC_NONE = 3'h0;
  localparam logic [2:0] HDLC_240 = 3'h1;
  localparam logic [2:0] HDLC_480 = 3'h2;
  localparam logic [2:0] HDLC_960 = 3'h3;
  localparam logic [2:0] HDLC_1920 = 3'h4;
  localparam logic [2:0] HDLC_2400 = 3'h5;

  typedef enum logic [2:0] {
    ST_STANDBY, ST_SYNC, ST_PROTO, ST_CM, ST_VENDOR, ST_OPER
  } rlc_state_t;

  typedef struct packed {
    logic [9:0] rsvd;
    logic [1:0] serdes_rate;
    logic [1:0] rsvd2;
    logic [1:0] lbr_cap;
    logic [2:0] rsvd3;
    logic [4:0] hdlc_en;
    logic [1:0] rsvd4;
    logic force_idle;
    logic bfn_rst_en;
    logic hfn_rst_en;
    logic cnt_mode;
    logic speedup;
    logic role;
  } rlc_ctrl_t;

  typedef struct packed {
    logic rx_lost;
    logic tx_dis;
    logic [2:0] hdlc;
    logic chg;
    logic [1:0] rate;
    logic [2:0] stup;
  } rlc_stat_t;

endpackage

// [rlc_core.sv]
`timescale 1ns/1ps
// Function
// - Two active-high resets clear transmit and receive subchannel state.
// - Role select 1 means controller node, 0 means radio node.
// - Timer speed-up bit shortens start-up dwell timers.
// - One enable bit per slow control rate, 240 to 2400 kHz.
// - Counter mode low: control words from init values; high: counters.
// - Hyperframe counter loads init while sync and its enable are set.
// - Basic-frame counter loads init while sync and its enable are set.
// - Two-bit cap limits highest negotiated line rate.
// - Force-idle drives start-up machine to standby.
// - Two-bit input gives rate the serializer is set up for.
// - Negotiated line rate shown on two-bit output after start-up.
// - Indicator raised when serializer needs a different rate.
// - Negotiated slow control rate shown on three-bit output.
// - Radio node mode drives active-high transmit disable.
// - Start-up state on three bits, 1 sync through 5 operation.
// - One-bit receive output flags loss of frame.
// - IQ data ports are 64-bit wide in both directions.
// - Control and status are bit-mapped, here through registers.
module rlc_core
  import rlc_pkg::*;
#(
  parameter int IQ_W = 64,
  parameter int DWELL_CYCLES = DWELL_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_sync,
  input wire logic hyperframe_tick,
  input wire logic link_lock_pin,
  input wire logic tx_fifo_rst,
  input wire logic rx_fifo_rst,
  input wire logic [IQ_W-1:0] tx_iq_data,
  output logic [IQ_W-1:0] link_tx_data,
  input wire logic [IQ_W-1:0] link_rx_data,
  output logic [IQ_W-1:0] rx_iq_data,
  output logic [7:0] ctrl_word_z64,
  output logic [7:0] ctrl_word_z128,
  output logic [7:0] ctrl_word_z192,
  output logic [5:0] tx_eth_ptr,
  output logic [1:0] rate_mode,
  output logic serdes_reconfig,
  output logic [2:0] tx_hdlc_mode,
  output logic tx_disable,
  output logic [2:0] startup_state,
  output logic rx_frame_lost
);

  if (IQ_W != 64 || DWELL_CYCLES < FAST_CYC || DWELL_CYCLES > 65535) begin
    $error("rlc_core: unsupported parameter values");
  end

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [1:0] rate_min(input logic [1:0] a,
      input logic [1:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [2:0] stup_code(input rlc_state_t s);
    case (s)
      ST_SYNC: return STUP_SYNC;
      ST_PROTO: return STUP_PROTO;
      ST_CM: return STUP_CM;
      ST_VENDOR: return STUP_VENDOR;
      ST_OPER: return STUP_OPER;
      default: return STUP_STANDBY;
    endcase
  endfunction

  function automatic logic [2:0] hdlc_pick(input logic [4:0] en);
    if (en[4]) return HDLC_2400;
    if (en[3]) return HDLC_1920;
    if (en[2]) return HDLC_960;
    if (en[1]) return HDLC_480;
    if (en[0]) return HDLC_240;
    return HDLC_NONE;
  endfunction

  rlc_ctrl_t ctrl_ff;
  logic [31:0] init_ff;
  logic [5:0] eth_ff;
  rlc_stat_t stat;
  rlc_state_t state_ff;
  rlc_state_t nxt_state;
  logic [15:0] timer_ff;
  logic [15:0] dwell_lim;
  logic lock_meta_ff;
  logic lock_ff;
  logic [15:0] lost_cnt_ff;
  logic lof_ff;
  logic [7:0] hfn_ff;
  logic [11:0] bfn_ff;
  logic [7:0] hfn_init;
  logic [11:0] bfn_init;
  logic [1:0] rate_ff;
  logic chg_ff;
  logic [2:0] hdlc_ff;
  logic txdis_ff;
  logic [7:0] aw_addr_ff;
  logic aw_have_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic w_have_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic [31:0] new_eth;
  logic [7:0] z64_ff;
  logic [7:0] z128_ff;
  logic [7:0] z192_ff;
  logic [IQ_W-1:0] ltx_ff;
  logic [IQ_W-1:0] rxiq_ff;

  assign hfn_init = init_ff[INIT_HFN_LSB +: 8];
  assign bfn_init = init_ff[INIT_BFN_LSB +: 12];

  // AXI4-Lite write channel
  assign s_axi_awready = aclk_en && !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = aclk_en && !w_have_ff && !bvalid_ff;
  assign do_write = aclk_en && aw_have_ff && w_have_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_have_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (aclk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (aclk_en) begin
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (aw_addr_ff == ADDR_CTRL || aw_addr_ff == ADDR_INIT ||
                     aw_addr_ff == ADDR_ETH) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign new_eth = apply_strb({26'h0, eth_ff}, w_data_ff, w_strb_ff);

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= rlc_ctrl_t'(CTRL_RST);
      init_ff <= INIT_RST;
    end else if (aclk_en && do_write) begin
      if (aw_addr_ff == ADDR_CTRL) begin
        ctrl_ff <= rlc_ctrl_t'(apply_strb(ctrl_ff, w_data_ff, w_strb_ff));
      end
      if (aw_addr_ff == ADDR_INIT) begin
        init_ff <= apply_strb(init_ff, w_data_ff, w_strb_ff);
      end
    end
  end

  // Ethernet pointer, cleared by transmit reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eth_ff <= ETH_RST;
    end else if (aclk_en) begin
      if (tx_fifo_rst) begin
        eth_ff <= ETH_RST;
      end else if (do_write && aw_addr_ff == ADDR_ETH &&
                   (new_eth[5:0] == 6'h00 ||
                    new_eth[5:0] >= ETH_PTR_MIN)) begin
        eth_ff <= new_eth[5:0];
      end
    end
  end
  assign tx_eth_ptr = eth_ff;

  // AXI4-Lite read channel
  assign s_axi_arready = aclk_en && !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (aclk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_CTRL: rdata_ff <= ctrl_ff;
          ADDR_INIT: rdata_ff <= init_ff;
          ADDR_ETH: rdata_ff <= {26'h0, eth_ff};
          ADDR_STAT: rdata_ff <= {21'h0, stat};
          ADDR_CNT: rdata_ff <= {4'h0, bfn_ff, 8'h00, hfn_ff};
          default: begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Link lock pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_meta_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else if (aclk_en) begin
      lock_meta_ff <= link_lock_pin;
      lock_ff <= lock_meta_ff;
    end
  end

  // Loss of frame detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lost_cnt_ff <= 16'h0000;
      lof_ff <= 1'b0;
    end else if (aclk_en) begin
      if (lock_ff) begin
        lost_cnt_ff <= 16'h0000;
        lof_ff <= 1'b0;
      end else if (lost_cnt_ff == 16'(LOF_CYC - 1)) begin
        lof_ff <= 1'b1;
      end else if (rx_fifo_rst) begin
        lost_cnt_ff <= 16'h0000;
        lof_ff <= 1'b0;
      end else begin
        lost_cnt_ff <= lost_cnt_ff + 16'h0001;
      end
    end
  end
  assign rx_frame_lost = lof_ff;

  // Start-up sequence
  assign dwell_lim = ctrl_ff.speedup ? 16'(FAST_CYC - 1) :
                     16'(DWELL_CYCLES - 1);

  always_comb begin
    nxt_state = state_ff;
    if (ctrl_ff.force_idle) begin
      nxt_state = ST_STANDBY;
    end else begin
      case (state_ff)
        ST_STANDBY: nxt_state = ST_SYNC;
        ST_SYNC: begin
          if (lock_ff && timer_ff >= dwell_lim) begin
            nxt_state = ST_PROTO;
          end
        end
        ST_PROTO: nxt_state = lof_ff ? ST_SYNC :
                              (timer_ff >= dwell_lim ? ST_CM : ST_PROTO);
        ST_CM: nxt_state = lof_ff ? ST_SYNC :
                           (timer_ff >= dwell_lim ? ST_VENDOR : ST_CM);
        ST_VENDOR: nxt_state = lof_ff ? ST_SYNC :
                               (timer_ff >= dwell_lim ? ST_OPER : ST_VENDOR);
        ST_OPER: nxt_state = lof_ff ? ST_SYNC : ST_OPER;
        default: nxt_state = ST_STANDBY;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_STANDBY;
      timer_ff <= 16'h0000;
    end else if (aclk_en) begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff || (state_ff == ST_SYNC && !lock_ff)) begin
        timer_ff <= 16'h0000;
      end else if (timer_ff < dwell_lim) begin
        timer_ff <= timer_ff + 16'h0001;
      end
    end
  end

  // Negotiated rates and transmit disable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_ff <= 2'h0;
      chg_ff <= 1'b0;
      hdlc_ff <= HDLC_NONE;
      txdis_ff <= 1'b0;
    end else if (aclk_en) begin
      if (state_ff == ST_VENDOR && nxt_state == ST_OPER) begin
        rate_ff <= rate_min(ctrl_ff.lbr_cap,
                            ctrl_ff.serdes_rate);
      end
      chg_ff <= (state_ff == ST_SYNC) &&
                (ctrl_ff.serdes_rate != ctrl_ff.lbr_cap);
      if (state_ff == ST_STANDBY) begin
        hdlc_ff <= HDLC_NONE;
      end else if (state_ff == ST_CM) begin
        hdlc_ff <= hdlc_pick(ctrl_ff.hdlc_en);
      end
      txdis_ff <= !ctrl_ff.role &&
                  (state_ff == ST_STANDBY || lof_ff);
    end
  end

  assign rate_mode = rate_ff;
  assign serdes_reconfig = chg_ff;
  assign tx_hdlc_mode = hdlc_ff;
  assign tx_disable = txdis_ff;
  assign startup_state = stup_code(state_ff);
  assign stat = '{rx_lost: lof_ff, tx_dis: txdis_ff, hdlc: hdlc_ff,
                  chg: chg_ff, rate: rate_ff, stup: stup_code(state_ff)};

  // Hyperframe and basic-frame counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hfn_ff <= 8'h00;
      bfn_ff <= 12'h000;
    end else if (aclk_en && ctrl_ff.role && ctrl_ff.cnt_mode) begin
      if (tx_sync && ctrl_ff.hfn_rst_en) begin
        hfn_ff <= hfn_init;
      end else if (hyperframe_tick) begin
        hfn_ff <= (hfn_ff == HFN_LAST) ? 8'h00 : hfn_ff + 8'h01;
      end
      if (tx_sync && ctrl_ff.bfn_rst_en) begin
        bfn_ff <= bfn_init;
      end else if (hyperframe_tick && hfn_ff == HFN_LAST) begin
        bfn_ff <= bfn_ff + 12'h001;
      end
    end
  end

  // Control word sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      z64_ff <= 8'h00;
      z128_ff <= 8'h00;
      z192_ff <= 8'h00;
    end else if (aclk_en && ctrl_ff.role) begin
      if (ctrl_ff.cnt_mode) begin
        z64_ff <= hfn_ff;
        z128_ff <= bfn_ff[7:0];
        z192_ff <= {4'h0, bfn_ff[11:8]};
      end else begin
        z64_ff <= hfn_init;
        z128_ff <= bfn_init[7:0];
        z192_ff <= {4'h0, bfn_init[11:8]};
      end
    end
  end
  assign ctrl_word_z64 = z64_ff;
  assign ctrl_word_z128 = z128_ff;
  assign ctrl_word_z192 = z192_ff;

  // IQ data stages, both 64 bits wide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ltx_ff <= '0;
      rxiq_ff <= '0;
    end else if (aclk_en) begin
      ltx_ff <= txdis_ff ? '0 : tx_iq_data;
      rxiq_ff <= rx_fifo_rst ? '0 : link_rx_data;
    end
  end
  assign link_tx_data = ltx_ff;
  assign rx_iq_data = rxiq_ff;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  force_idle_a: assert property (aclk_en && ctrl_ff.force_idle |=>
      startup_state == STUP_STANDBY)
    else $error("force idle did not reach standby");
  oper_code_a: assert property (state_ff == ST_OPER |->
      startup_state == STUP_OPER && stat.stup == STUP_OPER)
    else $error("operation state code wrong");
  hfn_load_a: assert property (aclk_en && ctrl_ff.role &&
      ctrl_ff.cnt_mode && tx_sync && ctrl_ff.hfn_rst_en |=>
      hfn_ff == $past(hfn_init))
    else $error("hyperframe counter not loaded");
  bfn_load_a: assert property (aclk_en && ctrl_ff.role &&
      ctrl_ff.cnt_mode && tx_sync && ctrl_ff.bfn_rst_en |=>
      bfn_ff == $past(bfn_init))
    else $error("basic frame counter not loaded");
  zword_direct_a: assert property (aclk_en && ctrl_ff.role &&
      !ctrl_ff.cnt_mode |=> ctrl_word_z64 == $past(hfn_init) &&
      ctrl_word_z128 == $past(bfn_init[7:0]))
    else $error("control words not taken from init values");
  tx_disable_a: assert property (aclk_en && !ctrl_ff.role &&
      state_ff == ST_STANDBY |=> tx_disable and
      (aclk_en |=> link_tx_data == '0))
    else $error("radio node transmit not disabled");
  lof_set_a: assert property (aclk_en && !lock_ff &&
      lost_cnt_ff == 16'(LOF_CYC - 1) |=> rx_frame_lost)
    else $error("loss of frame not flagged");
  eth_clear_a: assert property (aclk_en && tx_fifo_rst |=>
      tx_eth_ptr == 6'h00)
    else $error("transmit reset did not clear pointer");
  fast_dwell_a: assert property (aclk_en && state_ff == ST_PROTO &&
      ctrl_ff.speedup && !ctrl_ff.force_idle && !lof_ff &&
      timer_ff == 16'(FAST_CYC - 1) |=> state_ff == ST_CM)
    else $error("speed-up dwell not applied");
  rate_load_a: assert property (state_ff == ST_OPER &&
      $past(state_ff) == ST_VENDOR |-> rate_mode ==
      rate_min($past(ctrl_ff.lbr_cap), $past(ctrl_ff.serdes_rate)))
    else $error("negotiated rate wrong");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid)
    else $error("write response dropped");

  reach_oper_c: cover property (state_ff == ST_VENDOR ##1
      state_ff == ST_OPER);
  lof_c: cover property (state_ff == ST_OPER ##1 rx_frame_lost);
  axi_write_c: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
  hfn_wrap_c: cover property (hfn_ff == HFN_LAST ##[1:300] hfn_ff == 8'h00);

endmodule

// [rlc_far_end.sv]
`timescale 1ns/1ps
module rlc_far_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lock_req,
  output logic link_lock_pin,
  output logic [63:0] link_rx_data
);
  logic [63:0] seq_ff;
  // Fresh word every cycle, lock follows request a cycle late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_ff <= 64'h0123_4567_89AB_CDEF;
    end else begin
      seq_ff <= {seq_ff[62:0], seq_ff[63] ^ seq_ff[60]};
    end
    link_lock_pin <= lock_req;
  end
  assign link_rx_data = seq_ff;
endmodule

// [tb_radio_link_core_user_control.sv]
`timescale 1ns/1ps
module tb_radio_link_core_user_control;
  import rlc_pkg::*;
  logic aclk, aresetn, aclk_en, lock_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, rate_mode;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, serdes_reconfig, tx_disable;
  logic tx_sync, hyperframe_tick, link_lock_pin, tx_fifo_rst;
  logic rx_fifo_rst, rx_frame_lost;
  logic [63:0] tx_iq_data, link_tx_data, link_rx_data, rx_iq_data, prv;
  logic [7:0] ctrl_word_z64, ctrl_word_z128, ctrl_word_z192;
  logic [5:0] tx_eth_ptr;
  logic [2:0] tx_hdlc_mode, startup_state;
  int n_fail, n_compared;

  rlc_core #(.DWELL_CYCLES(16)) dut (
    .aclk, .aresetn, .aclk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_sync,
    .hyperframe_tick, .link_lock_pin, .tx_fifo_rst, .rx_fifo_rst,
    .tx_iq_data, .link_tx_data, .link_rx_data, .rx_iq_data,
    .ctrl_word_z64, .ctrl_word_z128, .ctrl_word_z192, .tx_eth_ptr,
    .rate_mode, .serdes_reconfig, .tx_hdlc_mode, .tx_disable,
    .startup_state, .rx_frame_lost
  );
  rlc_far_end far (.aclk, .aresetn, .lock_req, .link_lock_pin,
    .link_rx_data);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [63:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w, b;
    int k;
    k = 0;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && k < 50) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      k++;
    end
    chk("bresp", 64'({b, resp}), 64'({1'b1, er}));
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e, input logic [1:0] er);
    logic ar, r;
    int k;
    k = 0;
    r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && k < 50) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid && s_axi_rready;
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
      k++;
    end
    chk(nm, 64'({r, resp, rv}), 64'({1'b1, er, e}));
  endtask

  task automatic wait_st(input logic [2:0] c);
    int k;
    k = 0;
    while (startup_state !== c && k < 10) begin
      @(negedge aclk);
      k++;
    end
    chk("startup_state", 64'(startup_state), 64'(c));
  endtask

  task automatic t_reset();
    rc("ctrl", ADDR_CTRL, CTRL_RST, RESP_OKAY);
    rc("init", ADDR_INIT, INIT_RST, RESP_OKAY);
    rc("eth", ADDR_ETH, 32'(ETH_RST), RESP_OKAY);
    rc("unmapped", 8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask

  task automatic t_eth();
    logic [5:0] v[4] = '{6'h14, 6'h13, 6'h3F, 6'h00};
    logic [5:0] e[4] = '{6'h14, 6'h14, 6'h3F, 6'h00};
    foreach (v[i]) begin
      wr(ADDR_ETH, 32'(v[i]), RESP_OKAY);
      rc("eth", ADDR_ETH, 32'(e[i]), RESP_OKAY);
      chk("tx_eth_ptr", 64'(tx_eth_ptr), 64'(e[i]));
    end
    wr(ADDR_ETH, 32'h2D, RESP_OKAY);
    @(posedge aclk);
    tx_fifo_rst <= 1'b1;
    @(posedge aclk);
    tx_fifo_rst <= 1'b0;
    @(negedge aclk);
    chk("tx_eth_ptr", 64'(tx_eth_ptr), 64'h0);
  endtask

  task automatic t_cnt();
    wr(ADDR_INIT, 32'h0ABC_005A, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    repeat (3) @(negedge aclk);
    chk("z64", 64'(ctrl_word_z64), 64'h5A);
    chk("z128", 64'(ctrl_word_z128), 64'hBC);
    chk("z192", 64'(ctrl_word_z192), 64'h0A);
    wr(ADDR_INIT, 32'h0FFF_0094, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_001D, RESP_OKAY);
    tx_sync <= 1'b1;
    @(posedge aclk);
    tx_sync <= 1'b0;
    rc("count", ADDR_CNT, 32'h0FFF_0094, RESP_OKAY);
    repeat (2) begin
      hyperframe_tick <= 1'b1;
      @(posedge aclk);
      hyperframe_tick <= 1'b0;
      @(posedge aclk);
    end
    @(negedge aclk);
    chk("z64 wrap", 64'(ctrl_word_z64), 64'h00);
    chk("z128 wrap", 64'(ctrl_word_z128), 64'h00);
  endtask

  task automatic t_walk();
    logic [2:0] s[4] = '{STUP_PROTO, STUP_CM, STUP_VENDOR, STUP_OPER};
    wr(ADDR_CTRL, 32'h0032_1F23, RESP_OKAY);
    @(negedge aclk);
    chk("standby", 64'(startup_state), 64'(STUP_STANDBY));
    chk("hdlc idle", 64'(tx_hdlc_mode), 64'(HDLC_NONE));
    wr(ADDR_CTRL, 32'h0032_1F03, RESP_OKAY);
    wait_st(STUP_SYNC);
    @(negedge aclk);
    chk("reconfig", 64'(serdes_reconfig), 64'h1);
    foreach (s[i])
      wait_st(s[i]);
    chk("rate_mode", 64'(rate_mode), 64'h2);
    chk("hdlc", 64'(tx_hdlc_mode), 64'(HDLC_2400));
    chk("tx_disable", 64'(tx_disable), 64'h0);
    rc("stat", ADDR_STAT, 32'h0000_0155, RESP_OKAY);
    @(negedge aclk);
    chk("link_tx", link_tx_data, tx_iq_data);
    prv = link_rx_data;
    @(negedge aclk);
    chk("rx_iq", rx_iq_data, prv);
    @(posedge aclk);
    lock_req <= 1'b0;
    repeat (30) @(negedge aclk);
    chk("lof early", 64'(rx_frame_lost), 64'h0);
    repeat (20) @(negedge aclk);
    chk("lof", 64'(rx_frame_lost), 64'h1);
    chk("lof state", 64'(startup_state), 64'(STUP_SYNC));
    @(posedge aclk);
    lock_req <= 1'b1;
    rx_fifo_rst <= 1'b1;
    repeat (6) @(negedge aclk);
    chk("lof gone", 64'(rx_frame_lost), 64'h0);
    chk("rx_iq rst", rx_iq_data, 64'h0);
    @(posedge aclk);
    rx_fifo_rst <= 1'b0;
  endtask

  task automatic t_role();
    wr(ADDR_CTRL, 32'h0000_0020, RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk("re tx_disable", 64'(tx_disable), 64'h1);
    @(negedge aclk);
    chk("re link_tx", link_tx_data, 64'h0);
    chk("re hdlc", 64'(tx_hdlc_mode), 64'(HDLC_NONE));
    wr(ADDR_CTRL, 32'h0000_0021, RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk("rec tx_disable", 64'(tx_disable), 64'h0);
    wr(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
    aclk_en <= 1'b0;
    repeat (2) @(negedge aclk);
    chk("awready frozen", 64'(s_axi_awready), 64'h0);
    repeat (8) @(negedge aclk);
    chk("state frozen", 64'(startup_state), 64'(STUP_SYNC));
    @(posedge aclk);
    aclk_en <= 1'b1;
  endtask

  initial begin
    #150000;
    n_fail++;
    conclude();
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    aresetn = 1'b0;
    aclk_en = 1'b1;
    lock_req = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    tx_sync = 1'b0;
    hyperframe_tick = 1'b0;
    tx_fifo_rst = 1'b0;
    rx_fifo_rst = 1'b0;
    tx_iq_data = 64'hA5C3_0F96_5A3C_F069;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_eth();
    t_cnt();
    t_walk();
    t_role();
    conclude();
  end
endmodule
